// >>> verilog/vcd_pkg.sv
// Purpose: shared constants for the calibration sequencer and clock distribution
// Assumes: register indices as printed; byte address is four times the index
// Notes: registers hold 8-bit data in the low lane of a 32-bit word
package vcd_pkg;
    localparam int unsigned NUM_CH = 3;
    localparam int unsigned IDX_W = 10;
    // register indices
    localparam logic [9:0] IDX_CAL_CTRL = 10'h018;
    localparam logic [9:0] IDX_STATUS = 10'h01F;
    localparam logic [9:0] IDX_DIV_CNT0 = 10'h190;
    localparam logic [9:0] IDX_DIV_CFG0 = 10'h191;
    localparam logic [9:0] IDX_DIV_MISC0 = 10'h192;
    localparam logic [9:0] IDX_CH_STRIDE = 10'h003;
    localparam logic [9:0] IDX_VCO_DIV = 10'h1E0;
    localparam logic [9:0] IDX_SRC_SEL = 10'h1E1;
    localparam logic [9:0] IDX_UPDATE = 10'h232;
    // field positions
    localparam int unsigned CAL_START_BIT = 0;
    localparam int unsigned CAL_DIV_LSB = 1;
    localparam int unsigned STAT_BUSY_BIT = 7;
    localparam int unsigned STAT_DONE_BIT = 6;
    localparam int unsigned STAT_LOOP_BIT = 5;
    localparam int unsigned CNT_M_LSB = 4;
    localparam int unsigned CNT_N_LSB = 0;
    localparam int unsigned CFG_BYPASS_BIT = 7;
    localparam int unsigned CFG_START_HIGH_BIT = 5;
    localparam int unsigned CFG_PHASE_LSB = 0;
    localparam int unsigned MISC_DCC_OFF_BIT = 0;
    localparam int unsigned MISC_DIRECT_BIT = 1;
    localparam int unsigned MISC_DCC_ACT_BIT = 7;
    localparam int unsigned UPDATE_BIT = 0;
    // reset values
    localparam logic [7:0] CAL_CTRL_RST = 8'h00;
    localparam logic [7:0] DIV_CNT_RST = 8'h00;
    localparam logic [7:0] DIV_CFG_RST = 8'h00;
    localparam logic [7:0] DIV_MISC_RST = 8'h00;
    localparam logic [7:0] VCO_DIV_RST = 8'h00;
    localparam logic [7:0] SRC_SEL_RST = 8'h02;
    // timing
    localparam int unsigned CAL_CYCLES_DEF = 4400;
    localparam logic [2:0] VCO_SEL_MAX = 3'h4;

    typedef enum logic [1:0] {
        SRC_CLK_VDIV = 2'b00,
        SRC_CLK_DIRECT = 2'b01,
        SRC_VCO_VDIV = 2'b10,
        SRC_ILLEGAL = 2'b11
    } vcd_src_e;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_DONE = 2'b11
    } vcd_cal_e;
endpackage

// >>> verilog/vcd_chan_div.sv
// Purpose: one channel divider with high/low counts, start delay and start level
// Assumes: tick is a one-cycle pulse per divider input clock cycle
// Notes: duty-cycle correction is reported, half-cycle edges are not modelled
`timescale 1ns/100ps
module vcd_chan_div
    import vcd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // input clock and sync
    input wire logic tick,
    input wire logic sync,
    // settings
    input wire logic [3:0] m,
    input wire logic [3:0] n,
    input wire logic bypass,
    input wire logic dcc_off,
    input wire logic [4:0] phase,
    input wire logic start_high,
    // results
    output logic out,
    output logic dcc_act
);
    typedef struct packed {
        logic level;
        logic delaying;
        logic [4:0] cnt;
        logic dcc_act;
    } vcd_div_s;

    vcd_div_s s;
    vcd_div_s next_s;
    logic [4:0] div_max;
    logic [4:0] phase_eff;

    always_comb begin
        next_s = s;
        div_max = 5'({1'b0, n}) + 5'({1'b0, m}) + 5'h01;
        phase_eff = (phase > div_max) ? div_max : phase;
        next_s.dcc_act = !dcc_off && !bypass && ((m == n) || ({1'b0, m} == 5'({1'b0, n}) + 5'h01));
        if (sync) begin
            next_s.level = start_high;
            next_s.delaying = (phase_eff != 5'h00);
            next_s.cnt = phase_eff;
        end else if (tick) begin
            if (bypass) begin
                next_s.level = !s.level;
            end else if (s.delaying) begin
                if (s.cnt <= 5'h01) begin
                    next_s.delaying = 1'b0;
                    next_s.cnt = s.level ? 5'({1'b0, n}) : 5'({1'b0, m});
                end else begin
                    next_s.cnt = s.cnt - 5'h01;
                end
            end else if (s.cnt == 5'h00) begin
                next_s.level = !s.level;
                next_s.cnt = s.level ? 5'({1'b0, m}) : 5'({1'b0, n});
            end else begin
                next_s.cnt = s.cnt - 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out = s.level;
    assign dcc_act = s.dcc_act;

    property p_flip_to_high;
        @(posedge clk) disable iff (!reset_n)
        (tick && !sync && !bypass && !s.delaying && s.cnt == 5'h00 && !s.level)
            |=> (s.level && s.cnt == 5'({1'b0, $past(n)}));
    endproperty
    a_flip_to_high: assert property (p_flip_to_high) else $error("high phase not loaded with n");

    property p_sync_level;
        @(posedge clk) disable iff (!reset_n)
        sync |=> (s.level == $past(start_high));
    endproperty
    a_sync_level: assert property (p_sync_level) else $error("start level not applied on sync");

    property p_delay_bound;
        @(posedge clk) disable iff (!reset_n)
        sync |=> (s.cnt <= $past(div_max));
    endproperty
    a_delay_bound: assert property (p_delay_bound) else $error("start delay out of range");
endmodule

// >>> verilog/vcd_clock_ctrl.sv
// Purpose: calibration sequencer and distribution control behind an Avalon-MM slave
// Assumes: PFD_TICK, VCO_TICK and EXT_TICK are one-cycle pulses synchronous to CLK
// Notes: registers take effect only when an update strobe commits them
// What this block does
// - cal bit zero then one, each committed
// - first commit of one starts calibration
// - status bit reads one after calibration
// - cal clock is PFD over cal divider
// - calibration lasts fixed cal clock count
// - outputs held in sync while calibrating
// - loop closes after calibration, sync released
// - no automatic calibration on setting change
// - three dividers, 2 to 32 or bypass
// - high n+1, low m+1 input cycles
// - optional duty correction reported only, odd needs m=n+1
// - start delay bounded, selectable start level
// - source field picks clock and divider
// - VCO divider divides by 2 to 6
// - direct routing needs VCO divider path
// - per pair bit routes divider input out
// - count fields store cycles minus one
`timescale 1ns/100ps
module vcd_clock_ctrl
    import vcd_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = CAL_CYCLES_DEF
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Avalon-MM slave
    input wire logic [11:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // clock events
    input wire logic PFD_TICK,
    input wire logic VCO_TICK,
    input wire logic EXT_TICK,
    // distribution and loop
    output logic [NUM_CH-1:0] OUT_PAIR,
    output logic SYNC_ACTIVE,
    output logic LOOP_CLOSED
);
    if (CAL_CYCLES < 2 || CAL_CYCLES > 8191) begin : g_bad_cycles
        $error("CAL_CYCLES must lie in 2..8191");
    end

    localparam logic [12:0] CAL_LAST = 13'(CAL_CYCLES - 1);

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [7:0] sh_cal;
        logic [7:0] sh_vdiv;
        logic [7:0] sh_src;
        logic [NUM_CH-1:0][7:0] sh_cnt;
        logic [NUM_CH-1:0][7:0] sh_cfg;
        logic [NUM_CH-1:0][7:0] sh_misc;
        logic [7:0] act_cal;
        logic [7:0] act_vdiv;
        logic [7:0] act_src;
        logic [NUM_CH-1:0][7:0] act_cnt;
        logic [NUM_CH-1:0][7:0] act_cfg;
        logic [NUM_CH-1:0][7:0] act_misc;
        vcd_cal_e cal_st;
        logic cal_prev;
        logic [4:0] caldiv_cnt;
        logic [12:0] cal_cnt;
        logic done;
        logic loop_closed;
        logic [2:0] vdiv_cnt;
        logic vdiv_tick;
        logic [NUM_CH-1:0] direct_lvl;
        logic [NUM_CH-1:0] out;
        logic sync_out;
    } vcd_state_s;

    vcd_state_s s;
    vcd_state_s next_s;

    // channel number of a per-channel register, or NUM_CH when idx is not one
    function automatic logic [1:0] chan_of(input logic [9:0] idx, input logic [9:0] base);
        logic [1:0] ch;
        ch = 2'(NUM_CH);
        for (int i = 0; i < NUM_CH; i++) begin
            if (idx == base + 10'(i) * IDX_CH_STRIDE) begin
                ch = 2'(i);
            end
        end
        return ch;
    endfunction

    logic [9:0] idx;
    logic [1:0] ch_cnt;
    logic [1:0] ch_cfg;
    logic [1:0] ch_misc;
    logic cal_rise;
    logic sync;
    logic [4:0] caldiv_last;
    logic cal_tick;
    vcd_src_e src;
    logic use_vdiv;
    logic src_tick;
    logic chan_tick;
    logic [2:0] vdiv_sel;
    logic [NUM_CH-1:0] direct_en;
    logic [NUM_CH-1:0] start_lvl;
    logic [NUM_CH-1:0] div_out;
    logic [NUM_CH-1:0] dcc_act;
    logic [7:0] rd_byte;

    assign idx = ADDRESS[11:2];
    assign ch_cnt = chan_of(idx, IDX_DIV_CNT0);
    assign ch_cfg = chan_of(idx, IDX_DIV_CFG0);
    assign ch_misc = chan_of(idx, IDX_DIV_MISC0);
    assign sync = (s.cal_st == CAL_RUN);
    // cal_prev resets to zero so a first committed one counts as an edge
    assign cal_rise = s.act_cal[CAL_START_BIT] && !s.cal_prev;
    // cal divider 2, 4, 8 or 16
    assign caldiv_last = (5'h02 << s.act_cal[CAL_DIV_LSB +: 2]) - 5'h01;
    assign cal_tick = PFD_TICK && (s.caldiv_cnt == caldiv_last);

    assign src = vcd_src_e'(s.act_src[1:0]);
    assign use_vdiv = (src == SRC_CLK_VDIV) || (src == SRC_VCO_VDIV);
    assign src_tick = (src == SRC_VCO_VDIV) ? VCO_TICK : ((src == SRC_CLK_VDIV) ? EXT_TICK : 1'b0);
    assign chan_tick = use_vdiv ? s.vdiv_tick : ((src == SRC_CLK_DIRECT) ? EXT_TICK : 1'b0);
    // codes above four clip to divide by six
    assign vdiv_sel = (s.act_vdiv[2:0] > VCO_SEL_MAX) ? VCO_SEL_MAX : s.act_vdiv[2:0];

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            // direct routing only on the VCO divider path
            direct_en[i] = s.act_misc[i][MISC_DIRECT_BIT] && use_vdiv;
            start_lvl[i] = s.act_cfg[i][CFG_START_HIGH_BIT];
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (idx == IDX_CAL_CTRL) begin
            rd_byte = s.sh_cal;
        end else if (idx == IDX_STATUS) begin
            rd_byte[STAT_DONE_BIT] = s.done;
            rd_byte[STAT_BUSY_BIT] = sync;
            rd_byte[STAT_LOOP_BIT] = s.loop_closed;
        end else if (idx == IDX_VCO_DIV) begin
            rd_byte = s.sh_vdiv;
        end else if (idx == IDX_SRC_SEL) begin
            rd_byte = s.sh_src;
        end else if (ch_cnt != 2'(NUM_CH)) begin
            rd_byte = s.sh_cnt[ch_cnt];
        end else if (ch_cfg != 2'(NUM_CH)) begin
            rd_byte = s.sh_cfg[ch_cfg];
        end else if (ch_misc != 2'(NUM_CH)) begin
            rd_byte = s.sh_misc[ch_misc];
            rd_byte[MISC_DCC_ACT_BIT] = dcc_act[ch_misc];
        end
    end

    always_comb begin
        next_s = s;
        // bus: accept, answer one cycle later, release
        if (s.waitreq) begin
            if (READ || WRITE) begin
                next_s.waitreq = 1'b0;
                next_s.rdata = {24'h000000, rd_byte};
            end
        end else begin
            next_s.waitreq = 1'b1;
            if (WRITE && BYTEENABLE[0]) begin
                if (idx == IDX_CAL_CTRL) begin
                    next_s.sh_cal = WRITEDATA[7:0];
                end else if (idx == IDX_VCO_DIV) begin
                    next_s.sh_vdiv = WRITEDATA[7:0];
                end else if (idx == IDX_SRC_SEL) begin
                    next_s.sh_src = WRITEDATA[7:0];
                end else if (ch_cnt != 2'(NUM_CH)) begin
                    next_s.sh_cnt[ch_cnt] = WRITEDATA[7:0];
                end else if (ch_cfg != 2'(NUM_CH)) begin
                    next_s.sh_cfg[ch_cfg] = WRITEDATA[7:0];
                end else if (ch_misc != 2'(NUM_CH)) begin
                    next_s.sh_misc[ch_misc] = WRITEDATA[7:0];
                end else if (idx == IDX_UPDATE && WRITEDATA[UPDATE_BIT]) begin
                    // the strobe self-clears, so it has no storage
                    next_s.act_cal = s.sh_cal;
                    next_s.act_vdiv = s.sh_vdiv;
                    next_s.act_src = s.sh_src;
                    next_s.act_cnt = s.sh_cnt;
                    next_s.act_cfg = s.sh_cfg;
                    next_s.act_misc = s.sh_misc;
                end
            end
        end

        // calibration sequencer
        next_s.cal_prev = s.act_cal[CAL_START_BIT];
        if (cal_rise) begin
            // only an explicit committed request starts it
            next_s.cal_st = CAL_RUN;
            next_s.cal_cnt = 13'h0000;
            next_s.caldiv_cnt = 5'h00;
            next_s.done = 1'b0;
            next_s.loop_closed = 1'b0;
        end else begin
            unique case (s.cal_st)
                CAL_IDLE, CAL_DONE: begin
                end
                CAL_RUN: begin
                    if (PFD_TICK) begin
                        next_s.caldiv_cnt = cal_tick ? 5'h00 : s.caldiv_cnt + 5'h01;
                    end
                    if (cal_tick) begin
                        if (s.cal_cnt == CAL_LAST) begin
                            next_s.cal_st = CAL_DONE;
                            next_s.done = 1'b1;
                            next_s.loop_closed = 1'b1;
                        end else begin
                            next_s.cal_cnt = s.cal_cnt + 13'h0001;
                        end
                    end
                end
                default: begin
                    next_s.cal_st = CAL_IDLE;
                end
            endcase
        end

        next_s.vdiv_tick = 1'b0;
        if (use_vdiv && src_tick) begin
            if (s.vdiv_cnt >= vdiv_sel + 3'h1) begin
                next_s.vdiv_cnt = 3'h0;
                next_s.vdiv_tick = 1'b1;
            end else begin
                next_s.vdiv_cnt = s.vdiv_cnt + 3'h1;
            end
        end

        for (int i = 0; i < NUM_CH; i++) begin
            // raw divider input on the pair
            if (src_tick && direct_en[i]) begin
                next_s.direct_lvl[i] = !s.direct_lvl[i];
            end
            if (sync) begin
                next_s.out[i] = start_lvl[i];
                next_s.direct_lvl[i] = start_lvl[i];
            end else begin
                next_s.out[i] = direct_en[i] ? s.direct_lvl[i] : div_out[i];
            end
        end
        next_s.sync_out = (next_s.cal_st == CAL_RUN);
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s <= '0;
            s.waitreq <= 1'b1;
            s.sh_cal <= CAL_CTRL_RST;
            s.act_cal <= CAL_CTRL_RST;
            s.sh_vdiv <= VCO_DIV_RST;
            s.act_vdiv <= VCO_DIV_RST;
            s.sh_src <= SRC_SEL_RST;
            s.act_src <= SRC_SEL_RST;
            s.sh_cnt <= {NUM_CH{DIV_CNT_RST}};
            s.act_cnt <= {NUM_CH{DIV_CNT_RST}};
            s.sh_cfg <= {NUM_CH{DIV_CFG_RST}};
            s.act_cfg <= {NUM_CH{DIV_CFG_RST}};
            s.sh_misc <= {NUM_CH{DIV_MISC_RST}};
            s.act_misc <= {NUM_CH{DIV_MISC_RST}};
            s.cal_st <= CAL_IDLE;
        end else begin
            s <= next_s;
        end
    end

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        vcd_chan_div u_div (
            .clk(CLK),
            .reset_n(RESET_N),
            .tick(chan_tick),
            .sync(sync),
            .m(s.act_cnt[c][CNT_M_LSB +: 4]),
            .n(s.act_cnt[c][CNT_N_LSB +: 4]),
            .bypass(s.act_cfg[c][CFG_BYPASS_BIT]),
            .dcc_off(s.act_misc[c][MISC_DCC_OFF_BIT]),
            .phase(s.act_cfg[c][CFG_PHASE_LSB +: 5]),
            .start_high(s.act_cfg[c][CFG_START_HIGH_BIT]),
            .out(div_out[c]),
            .dcc_act(dcc_act[c])
        );
    end

    assign READDATA = s.rdata;
    assign WAITREQUEST = s.waitreq;
    assign OUT_PAIR = s.out;
    assign SYNC_ACTIVE = s.sync_out;
    assign LOOP_CLOSED = s.loop_closed;

    property p_start;
        @(posedge CLK) disable iff (!RESET_N)
        $rose(s.act_cal[CAL_START_BIT]) |=> (s.cal_st == CAL_RUN && s.cal_cnt == 13'h0000);
    endproperty
    a_start: assert property (p_start) else $error("committed rise did not start calibration");
    property p_no_auto;
        @(posedge CLK) disable iff (!RESET_N)
        (s.cal_st != CAL_RUN && !cal_rise) |=> (s.cal_st != CAL_RUN);
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("calibration started without request");
    property p_done_low;
        @(posedge CLK) disable iff (!RESET_N)
        (s.cal_st == CAL_RUN) |-> (!s.done && !s.loop_closed);
    endproperty
    a_done_low: assert property (p_done_low) else $error("done set during calibration");
    property p_done_high;
        @(posedge CLK) disable iff (!RESET_N)
        (s.cal_st == CAL_RUN && cal_tick && s.cal_cnt == CAL_LAST && !cal_rise)
            |=> (s.done && s.loop_closed && !SYNC_ACTIVE);
    endproperty
    a_done_high: assert property (p_done_high) else $error("calibration end not flagged");
    property p_cal_length;
        @(posedge CLK) disable iff (!RESET_N)
        (s.cal_st == CAL_RUN && s.cal_cnt < CAL_LAST) |=> (s.cal_st == CAL_RUN);
    endproperty
    a_cal_length: assert property (p_cal_length) else $error("calibration ended early");
    property p_cal_clock;
        @(posedge CLK) disable iff (!RESET_N)
        (s.cal_st == CAL_RUN && !cal_tick && !cal_rise) |=> $stable(s.cal_cnt);
    endproperty
    a_cal_clock: assert property (p_cal_clock) else $error("cal count moved without cal clock");
    property p_sync_hold;
        @(posedge CLK) disable iff (!RESET_N)
        (s.cal_st == CAL_RUN) |=> (OUT_PAIR == $past(start_lvl));
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("outputs moved during calibration");
    property p_illegal_src;
        @(posedge CLK) disable iff (!RESET_N)
        (src == SRC_ILLEGAL) |-> (!chan_tick && !src_tick);
    endproperty
    a_illegal_src: assert property (p_illegal_src) else $error("illegal source produced clock");
    property p_vdiv_range;
        @(posedge CLK) disable iff (!RESET_N)
        s.vdiv_tick |-> (s.vdiv_cnt == 3'h0 && $past(s.vdiv_cnt) == $past(vdiv_sel) + 3'h1);
    endproperty
    a_vdiv_range: assert property (p_vdiv_range) else $error("VCO divider ratio wrong");
    property p_direct;
        @(posedge CLK) disable iff (!RESET_N)
        !sync |=> ((OUT_PAIR & $past(direct_en)) == ($past(s.direct_lvl) & $past(direct_en)));
    endproperty
    a_direct: assert property (p_direct) else $error("direct routing not applied");
endmodule

// >>> verification/vcd_host_model.sv
// Purpose: host that programs the block over Avalon-MM
// Assumes: waitrequest is sampled at the rising CLK edge
// Notes: one request at a time, held until answered
`timescale 1ns/100ps
module vcd_host_model
    import vcd_pkg::*;
(
    // clock
    input wire logic clk,
    // bus
    output logic [11:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    initial begin
        address = 12'h000;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'h0;
    end

    task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= {24'h000000, d};
        byteenable <= 4'hF;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule

// >>> verification/vcd_clock_ctrl_tb.sv
// Purpose: self-checking bench for calibration and distribution
// Assumes: CAL_CYCLES shortened to 4; PFD and EXT ticks every 2 cycles
// Notes: run lengths are counted in CLK cycles after two settling periods
`timescale 1ns/100ps
module vcd_clock_ctrl_tb
    import vcd_pkg::*;
;
    localparam int unsigned CAL = 4;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] address;
    logic read, write;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic waitrequest, sync_active, loop_closed;
    logic pfd_tick = 1'b0;
    logic ext_tick = 1'b0;
    logic vco_tick = 1'b1;
    logic [NUM_CH-1:0] out_pair;
    int n_fail = 0;
    int checks_done = 0;
    int sync_len = 0;
    int hi, lo;
    int hi_e[3][3] = '{'{4, 2, 2}, '{6, 3, 1}, '{12, 6, 2}};
    int lo0[3] = '{6, 9, 18};
    logic [7:0] srcs[3] = '{8'h01, 8'h02, 8'h00};

    always #25 clk = ~clk;
    always @(posedge clk) begin
        pfd_tick <= ~pfd_tick;
        ext_tick <= ~ext_tick;
        if (sync_active === 1'b1) sync_len <= sync_len + 1;
    end

    vcd_clock_ctrl #(.CAL_CYCLES(CAL)) vcd_clock_ctrl_i (.CLK(clk), .RESET_N(reset_n), .ADDRESS(address),
        .READ(read), .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata),
        .WAITREQUEST(waitrequest), .PFD_TICK(pfd_tick), .VCO_TICK(vco_tick), .EXT_TICK(ext_tick),
        .OUT_PAIR(out_pair), .SYNC_ACTIVE(sync_active), .LOOP_CLOSED(loop_closed));
    vcd_host_model vcd_host_model_i (.clk(clk), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        vcd_host_model_i.xfer(idx, 1'b1, d, unused);
    endtask
    task automatic rd(input logic [9:0] idx);
        vcd_host_model_i.xfer(idx, 1'b0, 8'h00, q);
    endtask
    task automatic do_cal(input logic [7:0] ctl, input int exp, input logic [2:0] lvl);
        sync_len = 0;
        wr(IDX_CAL_CTRL, ctl);
        repeat (4) @(posedge clk);
        check("early", sync_active, 1'b0);
        wr(IDX_UPDATE, 8'h01);
        while (sync_active !== 1'b1) @(posedge clk);
        repeat (3) @(posedge clk);
        check("held", out_pair, lvl);
        rd(IDX_STATUS);
        check("busy done", q[6], 1'b0);
        while (sync_active === 1'b1) @(posedge clk);
        check("cal len", (sync_len >= exp - 2) && (sync_len <= exp + 2), 1'b1);
        check("loop", loop_closed, 1'b1);
        rd(IDX_STATUS);
        check("done", q[6], 1'b1);
    endtask
    task automatic meas(input int k);
        repeat (2) begin
            while (out_pair[k] !== 1'b0) @(posedge clk);
            while (out_pair[k] !== 1'b1) @(posedge clk);
        end
        hi = 0;
        lo = 0;
        while (out_pair[k] === 1'b1) begin
            hi++;
            @(posedge clk);
        end
        while (out_pair[k] === 1'b0) begin
            lo++;
            @(posedge clk);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        check("reset", {waitrequest, sync_active, loop_closed, out_pair}, 6'h20);
        rd(IDX_SRC_SEL);
        check("src reset", q, 32'h00000002);
        // read-only status and unmapped index ignore writes
        wr(IDX_STATUS, 8'hFF);
        wr(10'h004, 8'h5A);
        rd(10'h004);
        check("unmapped", q, 32'h00000000);
        do_cal(8'h01, CAL * 2 * 2, 3'h0);
        wr(IDX_DIV_CNT0, 8'h21);
        wr(IDX_UPDATE, 8'h01);
        repeat (8) @(posedge clk);
        check("no auto cal", sync_active, 1'b0);
        // recalibration needs a committed zero first
        wr(IDX_DIV_CFG0, 8'h20);
        wr(IDX_CAL_CTRL, 8'h00);
        wr(IDX_UPDATE, 8'h01);
        do_cal(8'h03, CAL * 4 * 2, 3'h1);
        wr(IDX_DIV_CFG0 + IDX_CH_STRIDE, 8'h80);
        wr(IDX_DIV_MISC0 + 2 * IDX_CH_STRIDE, 8'h02);
        wr(IDX_VCO_DIV, 8'h01);
        wr(IDX_UPDATE, 8'h01);
        rd(IDX_DIV_MISC0);
        check("dcc act", q, 32'h00000080);
        // VCO only ever routed via the VCO divider
        for (int s = 0; s < 3; s++) begin
            wr(IDX_SRC_SEL, srcs[s]);
            wr(IDX_UPDATE, 8'h01);
            for (int k = 0; k < 3; k++) begin
                meas(k);
                check("high run", hi, hi_e[s][k]);
                check("low run", lo, (k == 0) ? lo0[s] : hi_e[s][k]);
            end
        end
        // the reserved source code must leave every pair static
        wr(IDX_SRC_SEL, 8'h03);
        wr(IDX_UPDATE, 8'h01);
        repeat (2) @(posedge clk);
        q = {29'h00000000, out_pair};
        repeat (40) @(posedge clk);
        check("no source", {29'h00000000, out_pair}, q);
        complete_run();
    end
endmodule
